// ### include/mrws_pkg.sv
// Purpose: Constants and types for the module reset, wake and status block.
// Assumes: Core clock of 100 MHz.
// Notes: Long hold counts are derived from times in their own units.
// Contract
// - Low hardware reset input reboots the processor.
// - Factory-restore input is polled, not edge triggered.
// - Restore held low 6 s restores defaults, reboots.
// - Rising wake edge leaves low-power state.
// - Standby indicator asserted while in standby state.
// - Wireless status LED is active low.
// - System status LED is active high.
// - Link speed LED low at 100Mbps.
// - Activity LED low on link, toggles on traffic.
// - Thirteen configurable pins reset as inputs.
package mrws_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned RESET_HOLD_MS = 50;
  localparam int unsigned RESTORE_HOLD_S = 6;
  localparam int unsigned POLL_US = 1000;
  localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_MS * 1000 * CLK_MHZ;
  localparam int unsigned POLL_CYC = POLL_US * CLK_MHZ;
  localparam int unsigned RESTORE_POLLS = (RESTORE_HOLD_S * 1000000) / POLL_US;
  localparam int unsigned REBOOT_PULSE_CYC = 16;
  localparam int unsigned BLINK_CYC = 5000000;
  localparam int unsigned NUM_CFG_PINS = 13;
  localparam logic [12:0] CFG_DIR_RESET = 13'h0000;
  localparam logic [12:0] CFG_OUT_RESET = 13'h0000;
  typedef enum logic [3:0] {
    MRWS_RUN = 4'h1,
    MRWS_REBOOT = 4'h2,
    MRWS_RESTORE = 4'h4,
    MRWS_STANDBY = 4'h8
  } mrws_state_e;
endpackage : mrws_pkg

// ### include/mrws_sync_if.sv
`timescale 1ns/1ns
// Purpose: Carries raw pin levels in and synchronised levels out.
// Assumes: One clock domain.
// Notes: Three pins share the same two-stage synchroniser.
interface mrws_sync_if;
  logic [2:0] raw;
  logic [2:0] synced;
  modport sync (input raw, output synced);
  modport core (output raw, input synced);
endinterface : mrws_sync_if

// ### hdl/mrws_sync.sv
`timescale 1ns/1ns
// Purpose: Two-flop synchroniser for asynchronous control pins.
// Assumes: Reset and restore pins idle high, wake idles low; reset loads each idle level.
// Notes: The first stage feeds only the second stage.
module mrws_sync (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  mrws_sync_if.sync bus
);
  logic [2:0] meta_q;
  logic [2:0] sync_q;

  // Two stages per pin so metastability settles before use.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      meta_q <= 3'h3;
      sync_q <= 3'h3;
    end else begin
      meta_q <= bus.raw;
      sync_q <= meta_q;
    end
  end

  assign bus.synced = sync_q;
endmodule : mrws_sync

// ### hdl/mrws_top.sv
`timescale 1ns/1ns
// Purpose: Reset, factory-restore, wake, standby and status LED logic.
// Assumes: Pins are asynchronous to core_clk_i; status inputs are on core_clk_i.
// Notes: Configurable pins are three signals each; enable low means driving.
//   A low glitch on the hardware reset pin shorter than the hold never reboots the processor.
//   The restore pin is only looked at on poll ticks, so its hold is rounded to whole polls.
module mrws_top #(
  parameter int unsigned RESET_HOLD_CYC = mrws_pkg::RESET_HOLD_CYC,
  parameter int unsigned POLL_CYC = mrws_pkg::POLL_CYC,
  parameter int unsigned RESTORE_POLLS = mrws_pkg::RESTORE_POLLS,
  parameter int unsigned BLINK_CYC = mrws_pkg::BLINK_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic hw_reset_in_n_i,
  input wire logic factory_restore_n_i,
  input wire logic wake_i,
  input wire logic sleep_req_i,
  input wire logic wireless_up_i,
  input wire logic system_ok_i,
  input wire logic link_up_i,
  input wire logic link_100m_i,
  input wire logic link_traffic_i,
  input wire logic [12:0] cfg_dir_i,
  input wire logic [12:0] cfg_out_i,
  input wire logic [12:0] configurable_pin_in_i,
  output logic [12:0] configurable_pin_o,
  output logic [12:0] configurable_pin_oe_n_o,
  output logic [12:0] configurable_pin_val_o,
  output logic cpu_reset_n_o,
  output logic restore_defaults_o,
  output logic standby_indicator_o,
  output logic wireless_status_led_o,
  output logic system_status_led_o,
  output logic link_speed_led_o,
  output logic link_activity_led_o
);
  mrws_sync_if sif ();

  // Raw pins enter the shared synchroniser as one bundle.
  assign sif.raw = {wake_i, factory_restore_n_i, hw_reset_in_n_i};

  mrws_sync u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .bus(sif.sync)
  );

  // Synchronised pin levels, turned to an active-high meaning.
  wire hw_reset_s = ~sif.synced[0];
  wire restore_low_s = ~sif.synced[1];
  wire wake_s = sif.synced[2];

  mrws_pkg::mrws_state_e state_q, state_d;
  logic wake_prev_q;
  logic [31:0] rst_cnt_q;
  logic [31:0] poll_cnt_q;
  logic [31:0] hold_cnt_q;
  logic [7:0] pulse_cnt_q;
  logic [31:0] blink_cnt_q;
  logic blink_q;
  logic [12:0] cfg_in_meta_q;
  logic [12:0] cfg_in_q;

  // Decodes for edges, poll ticks and hold expiry.
  wire wake_rise = wake_s & ~wake_prev_q;
  wire poll_tick = (poll_cnt_q == POLL_CYC - 1);
  wire hold_done = restore_low_s && (hold_cnt_q >= RESTORE_POLLS - 1);
  wire rst_done = hw_reset_s && (rst_cnt_q >= 32'(RESET_HOLD_CYC - 1));
  wire pulse_done = (pulse_cnt_q == 8'(mrws_pkg::REBOOT_PULSE_CYC - 1));

  // The hardware reset is acted on by logic, independent of the poll.
  // Priority in run is hardware reset, then restore, then a sleep request.
  // Reboot is left only once the pin is high again, so a held pin keeps the processor in reset.
  always_comb begin
    state_d = state_q;
    case (state_q)
      mrws_pkg::MRWS_RUN: begin
        if (rst_done) state_d = mrws_pkg::MRWS_REBOOT;
        else if (poll_tick && hold_done) state_d = mrws_pkg::MRWS_RESTORE;
        else if (sleep_req_i) state_d = mrws_pkg::MRWS_STANDBY;
      end
      mrws_pkg::MRWS_RESTORE: begin
        state_d = mrws_pkg::MRWS_REBOOT;
      end
      mrws_pkg::MRWS_REBOOT: begin
        if (pulse_done && !hw_reset_s) state_d = mrws_pkg::MRWS_RUN;
      end
      mrws_pkg::MRWS_STANDBY: begin
        if (rst_done) state_d = mrws_pkg::MRWS_REBOOT;
        else if (wake_rise) state_d = mrws_pkg::MRWS_RUN;
      end
      default: state_d = mrws_pkg::MRWS_RUN;
    endcase
  end

  // State and edge register.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_q <= mrws_pkg::MRWS_RUN;
      wake_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wake_prev_q <= wake_s;
    end
  end

  // Reset low-time counter; a short glitch never reboots the processor.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || !hw_reset_s) rst_cnt_q <= 32'h0;
    else if (!rst_done) rst_cnt_q <= rst_cnt_q + 32'h1;
  end

  // Poll interval timer.
  // It runs from reset release, so the first tick comes a full period later.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || poll_tick) poll_cnt_q <= 32'h0;
    else poll_cnt_q <= poll_cnt_q + 32'h1;
  end

  // Restore hold timer counts polls; a high sample clears it at once.
  // The count stops at its end value, so it can never wrap around.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) hold_cnt_q <= 32'h0;
    else if (poll_tick) begin
      if (!restore_low_s) hold_cnt_q <= 32'h0;
      else if (!hold_done) hold_cnt_q <= hold_cnt_q + 32'h1;
    end
  end

  // Reboot pulse length, so the processor sees a clean reset.
  // The count restarts on every entry to reboot, so back-to-back reboots get full pulses.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || state_q != mrws_pkg::MRWS_REBOOT) pulse_cnt_q <= 8'h00;
    else if (!pulse_done) pulse_cnt_q <= pulse_cnt_q + 8'h01;
  end

  // Blink timer for the activity LED.
  // It runs free, so the LED phase is not tied to the start of traffic.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      blink_cnt_q <= 32'h0;
      blink_q <= 1'b0;
    end else if (blink_cnt_q == BLINK_CYC - 1) begin
      blink_cnt_q <= 32'h0;
      blink_q <= ~blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h1;
    end
  end

  // Next values of the control outputs. They are decoded from state_d so that
  // each output turns on the same edge as the state, not one cycle behind it.
  wire cpu_reset_n_d = (state_d != mrws_pkg::MRWS_REBOOT);
  wire restore_defaults_d = (state_d == mrws_pkg::MRWS_RESTORE);
  wire standby_indicator_d = (state_d == mrws_pkg::MRWS_STANDBY);

  // Next values of the status LEDs; each pin keeps its own polarity.
  // The status inputs are on core_clk_i already, so no synchroniser is spent on them.
  wire wireless_led_d = ~wireless_up_i;
  wire system_led_d = system_ok_i;
  wire speed_led_d = ~(link_up_i & link_100m_i);

  // The activity LED is solid on with a link, blinks with traffic and is off without a link.
  // Traffic shorter than one blink half period may not show at all; that is accepted.
  wire activity_led_d = ~link_up_i | (link_traffic_i & blink_q);

  // Control outputs; reset holds the processor in reset and clears the rest.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cpu_reset_n_o <= 1'b0;
      restore_defaults_o <= 1'b0;
      standby_indicator_o <= 1'b0;
    end else begin
      cpu_reset_n_o <= cpu_reset_n_d;
      restore_defaults_o <= restore_defaults_d;
      standby_indicator_o <= standby_indicator_d;
    end
  end

  // Status LED outputs; reset shows every LED dark whatever its polarity.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wireless_status_led_o <= 1'b1;
      system_status_led_o <= 1'b0;
      link_speed_led_o <= 1'b1;
      link_activity_led_o <= 1'b1;
    end else begin
      wireless_status_led_o <= wireless_led_d;
      system_status_led_o <= system_led_d;
      link_speed_led_o <= speed_led_d;
      link_activity_led_o <= activity_led_d;
    end
  end

  // Direction of the configurable pins. Direction 1 means output, so the
  // enable is its inverse: low while the pin is driven.
  wire [12:0] cfg_oe_n_d = ~cfg_dir_i;

  // Reset makes every configurable pin an input, so nothing is driven before set-up.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      configurable_pin_oe_n_o <= ~mrws_pkg::CFG_DIR_RESET;
      configurable_pin_o <= mrws_pkg::CFG_OUT_RESET;
    end else begin
      configurable_pin_oe_n_o <= cfg_oe_n_d;
      configurable_pin_o <= cfg_out_i;
    end
  end

  // Pin levels read back through two flip-flops and one output register.
  // Only cfg_in_q reads the first stage, so a metastable level never fans out.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cfg_in_meta_q <= 13'h0000;
      cfg_in_q <= 13'h0000;
      configurable_pin_val_o <= 13'h0000;
    end else begin
      cfg_in_meta_q <= configurable_pin_in_i;
      cfg_in_q <= cfg_in_meta_q;
      configurable_pin_val_o <= cfg_in_q;
    end
  end
endmodule : mrws_top

// ### test/mrws_board.sv
`timescale 1ns/1ns
// Purpose: Carrier board buttons on the reset, restore and wake pins.
// Assumes: Reset and restore buttons pull their pins low against a pull-up; wake is high while pressed.
// Notes: The bench times each press.
module mrws_board (
  input wire logic press_reset_i,
  input wire logic press_restore_i,
  input wire logic press_wake_i,
  output logic hw_reset_in_n_o,
  output logic factory_restore_n_o,
  output logic wake_o
);
  // A released button never leaves a pin asserted: reset and restore return high, wake returns low.
  assign hw_reset_in_n_o = !press_reset_i;
  assign factory_restore_n_o = !press_restore_i;
  assign wake_o = press_wake_i;
endmodule : mrws_board

// ### test/mrws_checker.sv
`timescale 1ns/1ns
// Purpose: Port assertions for the reset, wake and status block.
// Assumes: One clock and a synchronous active-low reset.
// Notes: Counters of low pin cycles give the hold that each action needs.
module mrws_checker #(
  parameter int unsigned RESET_HOLD_CYC = 8,
  parameter int unsigned POLL_CYC = 4,
  parameter int unsigned RESTORE_POLLS = 3
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic hw_reset_in_n_i,
  input wire logic factory_restore_n_i,
  input wire logic wake_i,
  input wire logic sleep_req_i,
  input wire logic wireless_up_i,
  input wire logic system_ok_i,
  input wire logic link_up_i,
  input wire logic link_100m_i,
  input wire logic link_traffic_i,
  input wire logic [12:0] configurable_pin_oe_n_o,
  input wire logic cpu_reset_n_o,
  input wire logic restore_defaults_o,
  input wire logic standby_indicator_o,
  input wire logic wireless_status_led_o,
  input wire logic system_status_led_o,
  input wire logic link_speed_led_o,
  input wire logic link_activity_led_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  int rst_low_q;
  int rest_low_q;
  // A high level restarts the count, so only an unbroken press counts.
  always_ff @(posedge core_clk_i) begin
    rst_low_q <= hw_reset_in_n_i ? 0 : rst_low_q + 1;
    rest_low_q <= factory_restore_n_i ? 0 : rest_low_q + 1;
  end
  chk_status_leds: assert property ($past(rst_n_i) |-> wireless_status_led_o == !$past(wireless_up_i)
    && system_status_led_o == $past(system_ok_i)) else $error("status led wrong");
  chk_speed_led: assert property ($past(rst_n_i) |-> link_speed_led_o == !($past(link_up_i) && $past(link_100m_i)))
    else $error("speed led wrong");
  chk_link_led: assert property ($past(rst_n_i) && !$past(link_traffic_i) |-> link_activity_led_o == !$past(link_up_i))
    else $error("activity led wrong");
  chk_pins_input: assert property (!$past(rst_n_i) |-> configurable_pin_oe_n_o == 13'h1FFF)
    else $error("pins not inputs after reset");
  chk_reboot_hold: assert property ($fell(cpu_reset_n_o) && !$past(restore_defaults_o) |-> rst_low_q >= RESET_HOLD_CYC)
    else $error("reboot on short press");
  chk_reboot_due: assert property (rst_low_q == RESET_HOLD_CYC + 5 |-> !cpu_reset_n_o)
    else $error("no reboot on long press");
  chk_restore_hold: assert property (restore_defaults_o |-> rest_low_q >= POLL_CYC * (RESTORE_POLLS - 1))
    else $error("restore on short press");
  chk_restore_boot: assert property (restore_defaults_o |=> !cpu_reset_n_o)
    else $error("no reboot after restore");
  chk_wake_exit: assert property (standby_indicator_o && $rose(wake_i) |-> ##[1:4] !standby_indicator_o)
    else $error("wake ignored");
  chk_standby_why: assert property ($rose(standby_indicator_o) |-> $past(sleep_req_i))
    else $error("standby without request");
endmodule : mrws_checker

// ### test/mrws_top_tb.sv
`timescale 1ns/1ns
// Purpose: Self-checking bench for the reset, wake and status block.
// Assumes: Short hold parameters stand in for the production counts.
// Notes: Inputs change 1 ns after the rising edge.
module mrws_top_tb;
  localparam int unsigned HOLD = 8;
  localparam int unsigned POLL = 4;
  localparam int unsigned POLLS = 3;
  logic core_clk_i, rst_n_i, hw_reset_in_n_i, factory_restore_n_i, wake_i, sleep_req_i, rcmd, dcmd, wcmd, seen;
  logic wireless_up_i, system_ok_i, link_up_i, link_100m_i, link_traffic_i, cpu_reset_n_o, restore_defaults_o;
  logic standby_indicator_o, wireless_status_led_o, system_status_led_o, link_speed_led_o, link_activity_led_o;
  logic [12:0] cfg_dir_i, cfg_out_i, configurable_pin_in_i, configurable_pin_o, configurable_pin_oe_n_o;
  logic [12:0] configurable_pin_val_o;
  int errors, tests_run;
  mrws_board board (.press_reset_i(rcmd), .press_restore_i(dcmd), .press_wake_i(wcmd),
    .hw_reset_in_n_o(hw_reset_in_n_i), .factory_restore_n_o(factory_restore_n_i), .wake_o(wake_i));
  mrws_top #(.RESET_HOLD_CYC(HOLD), .POLL_CYC(POLL), .RESTORE_POLLS(POLLS), .BLINK_CYC(4)) dut (.core_clk_i, .rst_n_i,
    .hw_reset_in_n_i, .factory_restore_n_i, .wake_i, .sleep_req_i, .wireless_up_i, .system_ok_i, .link_up_i,
    .link_100m_i, .link_traffic_i, .cfg_dir_i, .cfg_out_i, .configurable_pin_in_i, .configurable_pin_o,
    .configurable_pin_oe_n_o, .configurable_pin_val_o, .cpu_reset_n_o, .restore_defaults_o, .standby_indicator_o,
    .wireless_status_led_o, .system_status_led_o, .link_speed_led_o, .link_activity_led_o);
  // The restore pulse lasts one cycle, so it is latched for a later look.
  always @(posedge core_clk_i) if (restore_defaults_o === 1'b1) seen <= 1'b1;
  task cy(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : cy
  task cmp(input string nm, input logic [12:0] exp, input logic [12:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp
  task end_of_test;
    $display("Checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task t_pins;
    cmp("oe_reset", 13'h1FFF, configurable_pin_oe_n_o);
    cfg_dir_i = 13'h1555;
    cfg_out_i = 13'h0F0F;
    configurable_pin_in_i = 13'h0AAA;
    cy(4);
    cmp("oe", 13'h0AAA, configurable_pin_oe_n_o);
    cmp("pin_out", 13'h0505, configurable_pin_o & 13'h1555);
    cmp("pin_val", 13'h0AAA, configurable_pin_val_o & 13'h0AAA);
    $display("pins done");
  endtask : t_pins
  task t_midreset;
    rst_n_i = 1'b0;
    cy(3);
    cmp("oe_in_reset", 13'h1FFF, configurable_pin_oe_n_o);
    cmp("out_in_reset", 13'h0000, configurable_pin_o);
    cmp("cpu_in_reset", 13'h0, cpu_reset_n_o);
    rst_n_i = 1'b1;
    cy(1);
    cmp("cpu_after_reset", 13'h1, cpu_reset_n_o);
    cmp("oe_after_reset", 13'h0AAA, configurable_pin_oe_n_o);
    $display("mid-run reset done");
  endtask : t_midreset
  task t_leds;
    logic lo, hi;
    for (int i = 0; i < 8; i++) begin
      {wireless_up_i, link_up_i, link_100m_i} = i[2:0];
      system_ok_i = i[0];
      cy(2);
      cmp("wifi_led", !i[2], wireless_status_led_o);
      cmp("system_status_led", i[0], system_status_led_o);
      cmp("speed_led", !(i[1] & i[0]), link_speed_led_o);
      cmp("act_led", !i[1], link_activity_led_o);
    end
    lo = 1'b0;
    hi = 1'b0;
    link_up_i = 1'b1;
    link_traffic_i = 1'b1;
    for (int i = 0; i < 12; i++) begin
      cy(1);
      if (link_activity_led_o === 1'b0) lo = 1'b1;
      if (link_activity_led_o === 1'b1) hi = 1'b1;
    end
    cmp("act_blink_on", 13'h1, lo);
    cmp("act_blink_off", 13'h1, hi);
    link_traffic_i = 1'b0;
    cy(2);
    cmp("act_solid", 13'h0, link_activity_led_o);
    $display("leds done");
  endtask : t_leds
  task t_hwreset;
    rcmd = 1'b1;
    cy(4);
    rcmd = 1'b0;
    cy(HOLD + 4);
    cmp("short_reset", 13'h1, cpu_reset_n_o);
    rcmd = 1'b1;
    cy(HOLD + 6);
    cmp("long_reset", 13'h0, cpu_reset_n_o);
    rcmd = 1'b0;
    cy(24);
    cmp("reset_release", 13'h1, cpu_reset_n_o);
    $display("hw reset done");
  endtask : t_hwreset
  task t_restore;
    seen = 1'b0;
    dcmd = 1'b1;
    cy(POLL + 2);
    dcmd = 1'b0;
    cy(20);
    cmp("short_restore", 13'h0, seen);
    dcmd = 1'b1;
    cy(POLL * POLLS + 8);
    dcmd = 1'b0;
    cy(30);
    cmp("restore", 13'h1, seen);
    cmp("restore_boot", 13'h1, cpu_reset_n_o);
    $display("restore done");
  endtask : t_restore
  task t_standby;
    sleep_req_i = 1'b1;
    cy(1);
    sleep_req_i = 1'b0;
    cmp("standby", 13'h1, standby_indicator_o);
    cy(5);
    cmp("standby_hold", 13'h1, standby_indicator_o);
    wcmd = 1'b1;
    cy(4);
    cmp("wake", 13'h0, standby_indicator_o);
    wcmd = 1'b0;
    sleep_req_i = 1'b1;
    cy(1);
    sleep_req_i = 1'b0;
    cmp("standby_again", 13'h1, standby_indicator_o);
    rcmd = 1'b1;
    cy(HOLD + 6);
    cmp("standby_reset", 13'h0, cpu_reset_n_o);
    cmp("standby_left", 13'h0, standby_indicator_o);
    rcmd = 1'b0;
    cy(24);
    cmp("standby_reboot_end", 13'h1, cpu_reset_n_o);
    $display("standby done");
  endtask : t_standby
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    #50000;
    errors++;
    end_of_test;
  end
  initial begin
    {rst_n_i, rcmd, dcmd, wcmd, sleep_req_i, seen} = 6'h00;
    {wireless_up_i, system_ok_i, link_up_i, link_100m_i, link_traffic_i} = 5'h00;
    {cfg_dir_i, cfg_out_i, configurable_pin_in_i} = 39'h0;
    cy(10);
    rst_n_i = 1'b1;
    cy(1);
    t_pins;
    t_midreset;
    t_leds;
    t_hwreset;
    t_restore;
    t_standby;
    end_of_test;
  end
endmodule : mrws_top_tb
bind mrws_top mrws_checker #(.RESET_HOLD_CYC(RESET_HOLD_CYC), .POLL_CYC(POLL_CYC), .RESTORE_POLLS(RESTORE_POLLS)) chk (
  .core_clk_i, .rst_n_i, .hw_reset_in_n_i, .factory_restore_n_i, .wake_i, .sleep_req_i, .wireless_up_i,
  .system_ok_i, .link_up_i, .link_100m_i, .link_traffic_i, .configurable_pin_oe_n_o, .cpu_reset_n_o,
  .restore_defaults_o, .standby_indicator_o, .wireless_status_led_o, .system_status_led_o, .link_speed_led_o,
  .link_activity_led_o);
